// ### design/alarm_stop_and_power_sag_supervisor.sv
// Purpose: alarm stop selection, power cut ride-through, sag torque limit
// Assumes: all inputs synchronous to clk_i; motor_stopped_i from speed loop
// Notes:   registers reached over a plain address/strobe port
`timescale 1ns/1ns
`default_nettype none
module alarm_stop_and_power_sag_supervisor
#(
  parameter int CYCLES_PER_MS = supervisor_pkg::CYCLES_PER_MS
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [supervisor_pkg::ADDR_W-1:0] addr_i,
  input wire logic [supervisor_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [supervisor_pkg::DATA_W-1:0] rdata_o,
  // alarm and command inputs
  input wire logic group1_alarm_i,
  input wire logic group2_alarm_i,
  input wire logic undervoltage_alarm_i,
  input wire logic servo_off_cmd_i,
  // supply monitors
  input wire logic main_power_ok_i,
  input wire logic control_power_ok_i,
  input wire logic dc_bus_low_i,
  // motor feedback
  input wire logic motor_stopped_i,
  // drive controls
  output logic motor_power_on_o,
  output logic dynamic_brake_o,
  output logic zero_speed_ref_o,
  output logic servo_ready_out_o,
  // undervoltage warning and torque limit
  output logic undervoltage_warning_o,
  output logic torque_limit_active_o,
  output logic [6:0] torque_limit_o
);
  import supervisor_pkg::*;

  if (CYCLES_PER_MS < 1)
  begin : g_bad_rate
    $error("CYCLES_PER_MS must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  off_stop_type off_stop_select;
  logic gr2_stop_select;
  uv_mode_type undervoltage_limit_mode;
  ctl_mode_type control_mode;
  logic [9:0] power_cut_hold_time;
  logic [6:0] sag_torque_limit;
  logic [9:0] sag_limit_release_time;

  // write decode
  wire wr_ctrl = wr_i && (addr_i == REG_CTRL);
  wire wr_hold = wr_i && (addr_i == REG_HOLD);
  wire wr_sag = wr_i && (addr_i == REG_SAG_LIMIT);
  wire wr_rel = wr_i && (addr_i == REG_SAG_RELEASE);

  // out-of-range writes clamp so the timers never see an illegal value
  wire [9:0] w10 = wdata_i[9:0];
  wire [6:0] w7 = wdata_i[6:0];
  wire [9:0] hold_clamped = (w10 < HOLD_MIN) ? HOLD_MIN :
                            (w10 > HOLD_MAX) ? HOLD_MAX : w10;
  wire [6:0] sag_clamped = (w7 > SAG_LIMIT_MAX) ? SAG_LIMIT_MAX : w7;
  wire [9:0] rel_clamped = (w10 > RELEASE_MAX) ? RELEASE_MAX : w10;
  wire [1:0] w_off = wdata_i[OFF_SEL_LSB +: 2];
  wire [1:0] w_uv = wdata_i[UV_MODE_LSB +: 2];
  wire [1:0] w_ctl = wdata_i[CTL_MODE_LSB +: 2];

  // code 3 is not a valid selection; it falls back to the reset value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      off_stop_select <= OFF_BRK_BRK;
      gr2_stop_select <= 1'b0;
      undervoltage_limit_mode <= UV_NONE;
      control_mode <= CTL_POSITION;
    end
    else if (wr_ctrl)
    begin
      off_stop_select <= (w_off == 2'h3) ? OFF_BRK_BRK : off_stop_type'(w_off);
      gr2_stop_select <= wdata_i[GR2_SEL_BIT];
      undervoltage_limit_mode <= (w_uv == 2'h3) ? UV_NONE : uv_mode_type'(w_uv);
      control_mode <= (w_ctl == 2'h3) ? CTL_POSITION : ctl_mode_type'(w_ctl);
    end
  end

  // timing and limit values
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      power_cut_hold_time <= HOLD_RESET;
      sag_torque_limit <= SAG_LIMIT_RESET;
      sag_limit_release_time <= RELEASE_RESET;
    end
    else
    begin
      if (wr_hold)
        power_cut_hold_time <= hold_clamped;
      if (wr_sag)
        sag_torque_limit <= sag_clamped;
      if (wr_rel)
        sag_limit_release_time <= rel_clamped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // millisecond time base and power cut timer

  logic ms_tick;

  ms_tick_gen #(.CYCLES(CYCLES_PER_MS)) u_ms_tick
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(ms_tick)
  );

  logic [9:0] cut_ms;
  logic hold_expired;

  // counts ms since main supply loss, saturating at the hold limit
  always_ff @(posedge clk_i)
  begin
    if (rst_i || main_power_ok_i)
      cut_ms <= '0;
    else if (ms_tick && !hold_expired)
      cut_ms <= cut_ms + 1'b1;
  end

  // expiry latched until the supply is back
  always_ff @(posedge clk_i)
  begin
    if (rst_i || main_power_ok_i)
      hold_expired <= 1'b0;
    else if (cut_ms >= power_cut_hold_time)
      hold_expired <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // stop request classification

  // group2 select is meaningless under torque control
  wire gr2_honoured = (control_mode != CTL_TORQUE) && !gr2_stop_select;
  wire zero_speed_req = group2_alarm_i && gr2_honoured;
  // undervoltage alarm stops at once, whatever the hold timer says
  wire group1_req = group1_alarm_i || undervoltage_alarm_i ||
                    (group2_alarm_i && !gr2_honoured);
  // control power loss or an expired cut are an ordinary power-off
  wire power_stop = !control_power_ok_i || hold_expired;
  wire select_req = group1_req || servo_off_cmd_i;
  wire any_cause = power_stop || select_req || zero_speed_req;

  ////////////////////////////////////////////////////////////////////////////
  // stop sequencer

  stop_state_type state;
  stop_state_type next_state;
  logic coast_after;
  logic next_coast_after;

  // after-stop state shared by both alarm groups
  wire stop_hold_coast = (off_stop_select != OFF_BRK_BRK);
  wire [2:0] after_brk = coast_after ? ST_COAST_HOLD : ST_BRK_HOLD;
  wire [2:0] after_zero = stop_hold_coast ? ST_COAST_HOLD : ST_BRK_HOLD;

  always_comb
  begin
    next_state = state;
    next_coast_after = coast_after;
    unique case (state)
      ST_RUN, ST_ZERO_SPEED:
      begin
        if (power_stop)
        begin
          // supply loss always brakes dynamically
          next_state = ST_BRK_STOP;
          next_coast_after = 1'b0;
        end
        else if (select_req)
        begin
          next_coast_after = stop_hold_coast;
          if (off_stop_select == OFF_COAST_COAST)
            next_state = ST_COAST_STOP;
          else
            next_state = ST_BRK_STOP;
        end
        else if (zero_speed_req)
        begin
          if (state == ST_ZERO_SPEED && motor_stopped_i)
            next_state = stop_state_type'(after_zero);
          else
            next_state = ST_ZERO_SPEED;
        end
        else
          next_state = ST_RUN;
      end
      ST_BRK_STOP:
      begin
        if (motor_stopped_i)
          next_state = stop_state_type'(after_brk);
      end
      ST_COAST_STOP:
      begin
        if (motor_stopped_i)
          next_state = ST_COAST_HOLD;
      end
      ST_BRK_HOLD, ST_COAST_HOLD:
      begin
        // recovery once every cause has gone, e.g. main supply back
        if (!any_cause)
          next_state = ST_RUN;
      end
      default:
      begin
        next_state = ST_BRK_STOP;
        next_coast_after = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_BRK_HOLD;
      coast_after <= 1'b0;
    end
    else
    begin
      state <= next_state;
      coast_after <= next_coast_after;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive control outputs, registered from the next state, except ready, from alarms and supplies

  // power is on only while running or decelerating at zero speed
  wire next_power = (next_state == ST_RUN) ||
                    (next_state == ST_ZERO_SPEED);
  wire next_brk = (next_state == ST_BRK_STOP) || (next_state == ST_BRK_HOLD);
  wire next_zero = (next_state == ST_ZERO_SPEED);
  // ready falls on a long cut, lost control power or a live alarm
  wire next_ready = control_power_ok_i && !hold_expired && !group1_req &&
                    !group2_alarm_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      motor_power_on_o <= 1'b0;
      dynamic_brake_o <= 1'b1;
      zero_speed_ref_o <= 1'b0;
      servo_ready_out_o <= 1'b0;
    end
    else
    begin
      motor_power_on_o <= next_power;
      dynamic_brake_o <= next_brk;
      zero_speed_ref_o <= next_zero;
      servo_ready_out_o <= next_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // undervoltage warning and sag torque limit

  // mode 0 disables detection altogether
  wire warn_now = dc_bus_low_i && (|undervoltage_limit_mode);
  wire drive_mode = (undervoltage_limit_mode == UV_DRIVE);
  logic releasing;
  logic [9:0] release_ms;
  wire release_done = (release_ms >= sag_limit_release_time);

  // release window opens when the warning clears in drive mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !drive_mode || warn_now)
      releasing <= 1'b0;
    else if (undervoltage_warning_o)
      releasing <= 1'b1;
    else if (release_done)
      releasing <= 1'b0;
  end

  // ms counted within the release window
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !releasing)
      release_ms <= '0;
    else if (ms_tick && !release_done)
      release_ms <= release_ms + 1'b1;
  end

  // host mode only flags; the host does the limiting itself
  // the old warning bridges the edge before the release window opens
  wire next_limit_on = drive_mode && (warn_now || undervoltage_warning_o ||
                       (releasing && !release_done));
  wire [6:0] next_limit = next_limit_on ? sag_torque_limit : FULL_TORQUE;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      undervoltage_warning_o <= 1'b0;
      torque_limit_active_o <= 1'b0;
      torque_limit_o <= FULL_TORQUE;
    end
    else
    begin
      undervoltage_warning_o <= warn_now;
      torque_limit_active_o <= next_limit_on;
      torque_limit_o <= next_limit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read back

  wire [15:0] ctrl_word = {2'h0, control_mode, 2'h0, undervoltage_limit_mode,
                           3'h0, gr2_stop_select, 2'h0, off_stop_select};
  // status shows the sequencer and supply supervision state
  wire [15:0] status_word = {4'h0, torque_limit_active_o,
                             undervoltage_warning_o, servo_ready_out_o,
                             hold_expired, motor_power_on_o, dynamic_brake_o,
                             zero_speed_ref_o, releasing, 1'b0, state};
  wire [15:0] read_mux = (addr_i == REG_CTRL) ? ctrl_word :
                         (addr_i == REG_HOLD) ? {6'h00, power_cut_hold_time} :
                         (addr_i == REG_SAG_LIMIT) ? {9'h000, sag_torque_limit} :
                         (addr_i == REG_SAG_RELEASE) ?
                           {6'h00, sag_limit_release_time} :
                         (addr_i == REG_STATUS) ? status_word : 16'h0000;

  // data stands for exactly the cycle after the read strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !rd_i)
      rdata_o <= '0;
    else
      rdata_o <= read_mux;
  end

endmodule : alarm_stop_and_power_sag_supervisor
`default_nettype wire

// ### design/supervisor_pkg.sv
// Purpose: shared constants for the alarm stop and power sag supervisor
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes:   register offsets are word indices on the plain register port
package supervisor_pkg;

  // clock and time base
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_TICK = 1;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000 * MS_PER_TICK;

  // register port widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_HOLD = 4'h1;
  localparam logic [3:0] REG_SAG_LIMIT = 4'h2;
  localparam logic [3:0] REG_SAG_RELEASE = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;

  // control register field positions
  localparam int OFF_SEL_LSB = 0;
  localparam int GR2_SEL_BIT = 4;
  localparam int UV_MODE_LSB = 8;
  localparam int CTL_MODE_LSB = 12;

  // value ranges and values after reset
  localparam logic [9:0] HOLD_MIN = 10'h014;
  localparam logic [9:0] HOLD_MAX = 10'h3e8;
  localparam logic [9:0] HOLD_RESET = 10'h014;
  localparam logic [6:0] SAG_LIMIT_MAX = 7'h64;
  localparam logic [6:0] SAG_LIMIT_RESET = 7'h32;
  localparam logic [9:0] RELEASE_MAX = 10'h3e8;
  localparam logic [9:0] RELEASE_RESET = 10'h064;
  localparam logic [6:0] FULL_TORQUE = 7'h64;

  // stop selection codes
  typedef enum logic [1:0]
  {
    OFF_BRK_BRK = 2'b00,
    OFF_BRK_COAST = 2'b01,
    OFF_COAST_COAST = 2'b10
  } off_stop_type;

  // undervoltage limit modes
  typedef enum logic [1:0]
  {
    UV_NONE = 2'b00,
    UV_HOST = 2'b01,
    UV_DRIVE = 2'b10
  } uv_mode_type;

  // control modes
  typedef enum logic [1:0]
  {
    CTL_POSITION = 2'b00,
    CTL_SPEED = 2'b01,
    CTL_TORQUE = 2'b10
  } ctl_mode_type;

  // stop sequencer states
  typedef enum logic [2:0]
  {
    ST_RUN = 3'b000,
    ST_ZERO_SPEED = 3'b001,
    ST_BRK_STOP = 3'b010,
    ST_COAST_STOP = 3'b011,
    ST_BRK_HOLD = 3'b100,
    ST_COAST_HOLD = 3'b101
  } stop_state_type;

endpackage : supervisor_pkg

// ### design/ms_tick_gen.sv
// Purpose: one-cycle enable pulse once per millisecond
// Assumes: free-running divider, restarted only by reset
// Notes:   shorten CYCLES for simulation
`timescale 1ns/1ns
`default_nettype none
module ms_tick_gen
#(
  parameter int CYCLES = 100_000
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // tick out
  output logic tick_o
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;
  wire at_last = (count == LAST);

  // a zero-length period cannot be counted
  if (CYCLES < 1)
  begin : g_bad_cycles
    $error("ms_tick_gen: CYCLES must be at least 1");
  end

  // divider wraps at the last cycle of each period
  always_ff @(posedge clk_i)
  begin
    if (rst_i || at_last)
      count <= '0;
    else
      count <= count + 1'b1;
  end

  // pulse registered so it is glitch free
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tick_o <= 1'b0;
    else
      tick_o <= at_last;
  end
endmodule : ms_tick_gen
`default_nettype wire

// ### sim/supervisor_sva.sv
// Purpose: checker for stop, power cut and sag outputs of the supervisor
// Assumes: config is mirrored from register writes seen at the ports
// Notes: field code 3 and out-of-range sag limits are never written
`timescale 1ns/1ns
`default_nettype none
module supervisor_sva
  import supervisor_pkg::*;
(
  // clock, reset, register writes
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [supervisor_pkg::ADDR_W-1:0] addr_i,
  input wire logic [supervisor_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  // causes
  input wire logic group1_alarm_i,
  input wire logic group2_alarm_i,
  input wire logic undervoltage_alarm_i,
  input wire logic servo_off_cmd_i,
  input wire logic main_power_ok_i,
  input wire logic control_power_ok_i,
  input wire logic dc_bus_low_i,
  // drive outputs
  input wire logic motor_power_on_o,
  input wire logic dynamic_brake_o,
  input wire logic zero_speed_ref_o,
  input wire logic servo_ready_out_o,
  input wire logic undervoltage_warning_o,
  input wire logic torque_limit_active_o,
  input wire logic [6:0] torque_limit_o
);
  logic [15:0] ctrl;
  logic [6:0] sag;
  // running and free of any power stop
  wire quiet = motor_power_on_o && !zero_speed_ref_o && main_power_ok_i &&
    control_power_ok_i;
  wire g2_only = group2_alarm_i && !group1_alarm_i && !servo_off_cmd_i &&
    !undervoltage_alarm_i && quiet;
  wire zs_sel = !ctrl[4] && ctrl[13:12] != 2'h2;

  // mirror of the config, so stop choices can be predicted
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= 16'h0000;
      sag <= SAG_LIMIT_RESET;
    end
    else if (wr_i && addr_i == REG_CTRL)
      ctrl <= wdata_i;
    else if (wr_i && addr_i == REG_SAG_LIMIT)
      sag <= wdata_i[6:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_cut;
    !motor_power_on_o && !servo_ready_out_o;
  endsequence
  sequence s_zero_stop;
    zero_speed_ref_o && motor_power_on_o;
  endsequence

  a_off_cut: assert property (servo_off_cmd_i |=> !motor_power_on_o)
    else $error("motor power on after servo off");
  a_group1_cut: assert property (group1_alarm_i |=> s_cut)
    else $error("group1 alarm left power on");
  a_stop_brake: assert property (group1_alarm_i && quiet
    |=> dynamic_brake_o == (ctrl[1:0] != 2'h2))
    else $error("wrong brake for stop select");
  a_zero_speed: assert property (g2_only && zs_sel |=> s_zero_stop)
    else $error("no zero speed stop");
  a_gr2_brake: assert property (g2_only && !zs_sel
    |=> !motor_power_on_o && !zero_speed_ref_o)
    else $error("group2 did not act as group1");
  a_ctrl_loss: assert property (!control_power_ok_i
    |=> !motor_power_on_o && dynamic_brake_o)
    else $error("control loss did not brake");
  a_uv_alarm: assert property (undervoltage_alarm_i |=> s_cut)
    else $error("undervoltage alarm left power on");
  a_warn_level: assert property (undervoltage_warning_o ==
    $past(dc_bus_low_i && ctrl[9:8] != 2'h0))
    else $error("warning does not follow low bus");
  a_host_mode: assert property (ctrl[9:8] == 2'h1
    |-> torque_limit_o == FULL_TORQUE && !torque_limit_active_o)
    else $error("device limits torque in host mode");
  a_sag_value: assert property (torque_limit_active_o
    |-> torque_limit_o == sag)
    else $error("limit differs from sag setting");
  a_drive_limit: assert property ($rose(undervoltage_warning_o) &&
    ctrl[9:8] == 2'h2 |-> ##[0:1] torque_limit_active_o)
    else $error("no device limit on warning");
  a_release_hold: assert property ($fell(undervoltage_warning_o) &&
    ctrl[9:8] == 2'h2 |-> torque_limit_active_o)
    else $error("limit dropped as warning cleared");
  a_ctrl_ready: assert property (!control_power_ok_i
    |=> !servo_ready_out_o)
    else $error("servo ready kept without control power");
endmodule : supervisor_sva

bind alarm_stop_and_power_sag_supervisor supervisor_sva u_sva (.clk_i, .rst_i,
  .addr_i, .wdata_i, .wr_i, .group1_alarm_i, .group2_alarm_i,
  .undervoltage_alarm_i, .servo_off_cmd_i, .main_power_ok_i,
  .control_power_ok_i, .dc_bus_low_i, .motor_power_on_o, .dynamic_brake_o,
  .zero_speed_ref_o, .servo_ready_out_o, .undervoltage_warning_o,
  .torque_limit_active_o, .torque_limit_o);
`default_nettype wire

// ### sim/host_model.sv
// Purpose: host motion controller beside the drive
// Assumes: servo off is asked for by the bench
// Notes: the host torque limit is only a flag, its level a parameter
`timescale 1ns/1ns
`default_nettype none
module host_model
#(
  // above vertical holding torque, low enough for a soft restart
  parameter logic [6:0] LIMIT_PCT = 7'h3c
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench request and drive warning
  input wire logic off_req_i,
  input wire logic warning_i,
  // toward the drive
  output logic servo_off_cmd_o,
  output logic [6:0] host_limit_o
);
  // limit kept until the warning has gone, never dropped early
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      servo_off_cmd_o <= 1'b0;
      host_limit_o <= 7'h64;
    end
    else
    begin
      servo_off_cmd_o <= off_req_i;
      host_limit_o <= warning_i ? LIMIT_PCT : 7'h64;
    end
  end
endmodule : host_model
`default_nettype wire

// ### sim/test_alarm_stop_and_power_sag_supervisor.sv
// Purpose: directed test of stop choice, power cut ride-through, sag limit
// Assumes: a millisecond is shortened to MS clock cycles
// Notes: expectations follow the register and timing settings used here
`timescale 1ns/1ns
`default_nettype none
module test_alarm_stop_and_power_sag_supervisor;
  import supervisor_pkg::*;
  localparam int MS = 10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0, rd_i = 1'b0, group1_alarm_i = 1'b0, group2_alarm_i = 1'b0;
  logic undervoltage_alarm_i = 1'b0, off_req = 1'b0, main_power_ok_i = 1'b1;
  logic control_power_ok_i = 1'b1, dc_bus_low_i = 1'b0, motor_stopped_i = 1'b0;
  logic servo_off_cmd_i, motor_power_on_o, dynamic_brake_o, zero_speed_ref_o;
  logic servo_ready_out_o, undervoltage_warning_o, torque_limit_active_o;
  logic [15:0] rdata_o;
  logic [6:0] torque_limit_o;
  // case table: [2] gr2 select, [1:0] control mode
  logic [2:0] g2_case [4] = '{3'h0, 3'h1, 3'h4, 3'h2};
  int n_errors = 0, n_tests = 0, cycles = 0;

  alarm_stop_and_power_sag_supervisor #(.CYCLES_PER_MS(MS)) dut (.clk_i,
    .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .group1_alarm_i,
    .group2_alarm_i, .undervoltage_alarm_i, .servo_off_cmd_i, .main_power_ok_i,
    .control_power_ok_i, .dc_bus_low_i, .motor_stopped_i, .motor_power_on_o,
    .dynamic_brake_o, .zero_speed_ref_o, .servo_ready_out_o,
    .undervoltage_warning_o, .torque_limit_active_o, .torque_limit_o);
  host_model host (.clk_i, .rst_i, .off_req_i(off_req),
    .warning_i(undervoltage_warning_o), .servo_off_cmd_o(servo_off_cmd_i),
    .host_limit_o());

  ////////////////////////////////////////////////////////////////////////////
  // clock, and a cycle ceiling of 6000, well above the under one thousand needed
  initial
    forever #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    check("rdata_o", exp, rdata_o);
  endtask : rd

  // sampled on the falling edge, where registered outputs have settled
  task automatic outs(input logic p, input logic b, input logic z);
    @(negedge clk_i);
    check("motor_power_on_o", p, motor_power_on_o);
    check("dynamic_brake_o", b, dynamic_brake_o);
    check("zero_speed_ref_o", z, zero_speed_ref_o);
  endtask : outs

  // finish the stop, check the hold state, clear causes, expect a restart
  task automatic recover(input logic dbh);
    step(1);
    motor_stopped_i <= 1'b1;
    step(3);
    outs(1'b0, dbh, 1'b0);
    step(1);
    {group1_alarm_i, group2_alarm_i, undervoltage_alarm_i, off_req} <= 4'h0;
    {main_power_ok_i, control_power_ok_i} <= 2'h3;
    step(3);
    motor_stopped_i <= 1'b0;
    step(2);
    outs(1'b1, 1'b0, 1'b0);
    check("servo_ready_out_o", 1'b1, servo_ready_out_o);
  endtask : recover

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    step(16);
    rst_i <= 1'b0;
    rd(REG_CTRL, 16'h0000);
    rd(REG_HOLD, 16'h0014);
    rd(REG_SAG_LIMIT, 16'h0032);
    rd(REG_SAG_RELEASE, 16'h0064);
    rd(4'h9, 16'h0000);
    wr(REG_STATUS, 16'hffff);
    rd(REG_STATUS, 16'h0280);
    wr(REG_HOLD, 16'h0005);
    rd(REG_HOLD, 16'h0014);
    wr(REG_HOLD, 16'h03ff);
    rd(REG_HOLD, 16'h03e8);
    wr(REG_SAG_RELEASE, 16'h03ff);
    rd(REG_SAG_RELEASE, 16'h03e8);
    wr(REG_HOLD, 16'h0014);
    for (int s = 0; s < 3; s++)
    begin
      wr(REG_CTRL, {14'h0000, s[1:0]});
      step(1);
      group1_alarm_i <= 1'b1;
      step(2);
      outs(1'b0, s != 2, 1'b0);
      recover(s == 0);
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(REG_CTRL, {2'h0, g2_case[k][1:0], 7'h00, g2_case[k][2], 4'h0});
      step(1);
      group2_alarm_i <= 1'b1;
      step(2);
      outs(g2_case[k] == 3'h0 || g2_case[k] == 3'h1,
        g2_case[k] == 3'h4 || g2_case[k] == 3'h2,
        g2_case[k] == 3'h0 || g2_case[k] == 3'h1);
      recover(1'b1);
    end
    wr(REG_CTRL, 16'h0000);
    step(1);
    main_power_ok_i <= 1'b0;
    step(15 * MS);
    outs(1'b1, 1'b0, 1'b0);
    check("servo_ready_out_o", 1'b1, servo_ready_out_o);
    step(1);
    main_power_ok_i <= 1'b1;
    step(3);
    main_power_ok_i <= 1'b0;
    step(23 * MS);
    outs(1'b0, 1'b1, 1'b0);
    check("servo_ready_out_o", 1'b0, servo_ready_out_o);
    recover(1'b1);
    // control loss, undervoltage alarm, servo off, each inside a short cut
    for (int k = 0; k < 3; k++)
    begin
      step(1);
      main_power_ok_i <= 1'b0;
      control_power_ok_i <= (k != 0);
      undervoltage_alarm_i <= (k == 1);
      off_req <= (k == 2);
      step(3);
      outs(1'b0, 1'b1, 1'b0);
      recover(1'b1);
    end
    wr(REG_SAG_LIMIT, 16'h001e);
    wr(REG_SAG_RELEASE, 16'h0005);
    wr(REG_CTRL, 16'h0200);
    step(1);
    dc_bus_low_i <= 1'b1;
    step(3);
    @(negedge clk_i);
    check("undervoltage_warning_o", 1'b1, undervoltage_warning_o);
    check("torque_limit_active_o", 1'b1, torque_limit_active_o);
    check("torque_limit_o", 7'h1e, torque_limit_o);
    step(1);
    dc_bus_low_i <= 1'b0;
    step(3 * MS);
    @(negedge clk_i);
    check("undervoltage_warning_o", 1'b0, undervoltage_warning_o);
    check("torque_limit_o", 7'h1e, torque_limit_o);
    step(5 * MS);
    @(negedge clk_i);
    check("torque_limit_o", 7'h64, torque_limit_o);
    wr(REG_CTRL, 16'h0100);
    step(1);
    dc_bus_low_i <= 1'b1;
    step(3);
    @(negedge clk_i);
    check("undervoltage_warning_o", 1'b1, undervoltage_warning_o);
    check("torque_limit_o", 7'h64, torque_limit_o);
    wr(REG_CTRL, 16'h0000);
    step(3);
    @(negedge clk_i);
    check("undervoltage_warning_o", 1'b0, undervoltage_warning_o);
    summarize();
  end
endmodule : test_alarm_stop_and_power_sag_supervisor
`default_nettype wire
